// *** verif/serial_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(
  parameter int BIT_CYCLES = 8
) (
  input wire logic pclk,
  output logic line
);
  // The line rests at the mark level between frames, as a pulled-up line would.
  initial line = 1'b1;

  // Sends one 8N1 frame, least significant bit first; stop may be forced low.
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] fr;
    fr = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      line <= fr[i];
      repeat (BIT_CYCLES - 1) @(posedge pclk);
    end
    @(posedge pclk);
    line <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "uart_irq_params.svh"
module tb;
  import uart_irq_pkg::*;
  localparam int BITC = 8;
  localparam logic [23:0] RIDX [5] = '{`SER_CTRL_IDX, `DMA_MODE0_IDX, `DMA_MODE1_IDX,
    `IRQ_MASK_IDX, `SER_STAT_IDX};
  localparam logic [31:0] RVAL [5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h84};
  localparam logic [7:0] CTRLS [5] = '{8'h80, 8'h04, 8'h84, 8'h40, 8'h00};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_pin, tx_pin, irq, err;
  logic [31:0] paddr, pwdata, prdata, rd, lfsr, v;
  logic [1:0] dma_done_evt, dsel;
  logic [23:0] di;
  logic [7:0] b0, b1, tb_byte;
  irq_req_s irq_req;
  int errors, n_compared;

  uart_irq_enable_status #(.BIT_CYCLES(BITC)) dut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .dma_done_evt(dma_done_evt), .irq_req(irq_req), .irq(irq));
  serial_peer #(.BIT_CYCLES(BITC)) peer (.pclk(pclk), .line(rx_pin));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Only valid while the transmitter is idle, so both transmit events stand.
  function automatic logic [5:0] exp_irq(input logic [7:0] c, input logic full,
      input logic ovr, input logic [1:0] dm);
    return {dm, ovr & c[`CTRL_RX_IE], full & c[`CTRL_RX_IE], c[`CTRL_TXD_IE], c[`CTRL_TXE_IE]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_req(input logic [5:0] exp);
    chk({26'h0, irq_req}, {26'h0, exp});
  endtask

  task automatic tally_and_finish();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // The request is held until pready is seen at a rising edge, for up to 100 cycles; a longer wait counts as an error.
  task automatic xfer(input logic wr, input logic [23:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {6'h0, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 100) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 100) errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  initial begin
    int i;
    errors = 0;
    n_compared = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    dma_done_evt = 2'b00;
    lfsr = 32'h86dbeab4;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_req(6'h00);
    chk({30'h0, tx_pin, irq}, 32'h2);
    foreach (RIDX[k]) begin
      xfer(1'b0, RIDX[k], 32'h0);
      chk(rd, RVAL[k]);
    end
    xfer(1'b0, 24'hffff86, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    foreach (CTRLS[k]) begin
      xfer(1'b1, `SER_CTRL_IDX, {24'h0, CTRLS[k]});
      cyc(3);
      chk_req(exp_irq(CTRLS[k], 1'b0, 1'b0, 2'b00));
    end
    for (int ch = 0; ch < 2; ch++) begin
      di = ch[0] ? `DMA_MODE1_IDX : `DMA_MODE0_IDX;
      dsel = ch[0] ? 2'b10 : 2'b01;
      lfsr = next_rand(lfsr);
      v = (lfsr & ~32'h0001_0000) | 32'h0000_0100;
      xfer(1'b1, di, v);
      @(posedge pclk);
      dma_done_evt <= dsel;
      @(posedge pclk);
      dma_done_evt <= 2'b00;
      cyc(3);
      chk_req(exp_irq(8'h00, 1'b0, 1'b0, dsel));
      xfer(1'b0, di, 32'h0);
      chk(rd, v | 32'h0001_0000);
      xfer(1'b1, di, (v & ~32'h0000_0100) | 32'h0001_0000);
      cyc(3);
      chk_req(6'h00);
      xfer(1'b1, di, 32'h0);
    end
    xfer(1'b1, `IRQ_STAT_IDX, 32'h3f);
    xfer(1'b0, `IRQ_STAT_IDX, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b1, `IRQ_MASK_IDX, 32'h3f);
    xfer(1'b1, `SER_CTRL_IDX, 32'h80);
    cyc(3);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b0, `IRQ_STAT_IDX, 32'h0);
    chk(rd, 32'h1);
    xfer(1'b1, `IRQ_MASK_IDX, 32'h3e);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, `IRQ_MASK_IDX, 32'h3f);
    xfer(1'b1, `IRQ_STAT_IDX, 32'h1);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    lfsr = next_rand(lfsr);
    b0 = lfsr[7:0];
    // The second character must differ from the first, or a lost overrun could not be seen.
    b1 = (lfsr[15:8] == b0) ? ~b0 : lfsr[15:8];
    xfer(1'b1, `SER_CTRL_IDX, 32'h50);
    peer.send(b0, 1'b1);
    cyc(BITC);
    chk_req(exp_irq(8'h50, 1'b1, 1'b0, 2'b00));
    // A zero written before any read that saw the flag set must not clear it.
    xfer(1'b1, `SER_STAT_IDX, 32'h0);
    xfer(1'b0, `SER_STAT_IDX, 32'h0);
    chk(rd & 32'h60, 32'h40);
    xfer(1'b0, `RX_BUF_IDX, 32'h0);
    chk(rd, {24'h0, b0});
    xfer(1'b1, `SER_CTRL_IDX, 32'h40);
    xfer(1'b0, `SER_STAT_IDX, 32'h0);
    chk(rd & 32'h60, 32'h40);
    xfer(1'b1, `SER_CTRL_IDX, 32'h50);
    peer.send(b1, 1'b1);
    cyc(BITC);
    chk_req(exp_irq(8'h50, 1'b1, 1'b1, 2'b00));
    // Full was already read as 1 and overrun not yet, so this zero may clear only full.
    xfer(1'b1, `SER_STAT_IDX, 32'h0);
    xfer(1'b0, `SER_STAT_IDX, 32'h0);
    chk(rd & 32'h60, 32'h20);
    xfer(1'b0, `RX_BUF_IDX, 32'h0);
    chk(rd, {24'h0, b0});
    xfer(1'b1, `SER_STAT_IDX, 32'h60);
    xfer(1'b0, `SER_STAT_IDX, 32'h0);
    chk(rd & 32'h60, 32'h20);
    xfer(1'b1, `SER_STAT_IDX, 32'h0);
    xfer(1'b0, `SER_STAT_IDX, 32'h0);
    chk(rd & 32'h60, 32'h0);
    xfer(1'b1, `SER_STAT_IDX, 32'h60);
    xfer(1'b0, `SER_STAT_IDX, 32'h0);
    chk(rd & 32'h60, 32'h0);
    // A frame with a low stop bit is dropped, and so is any frame while reception is off.
    peer.send(b1, 1'b0);
    cyc(BITC);
    xfer(1'b0, `SER_STAT_IDX, 32'h0);
    chk(rd & 32'h60, 32'h0);
    xfer(1'b1, `SER_CTRL_IDX, 32'h40);
    peer.send(b1, 1'b1);
    cyc(BITC);
    xfer(1'b0, `SER_STAT_IDX, 32'h0);
    chk(rd & 32'h60, 32'h0);
    xfer(1'b0, `RX_BUF_IDX, 32'h0);
    chk(rd, {24'h0, b0});
    xfer(1'b1, `SER_CTRL_IDX, 32'h00);
    xfer(1'b1, `TX_BUF_IDX, 32'ha5);
    v = 32'h0;
    repeat (4 * BITC) begin
      @(posedge pclk);
      if (tx_pin !== 1'b1) v = 32'h1;
    end
    chk(v, 32'h0);
    xfer(1'b1, `SER_CTRL_IDX, 32'h20);
    i = 0;
    while (tx_pin !== 1'b0 && i < 4 * BITC) begin
      @(posedge pclk);
      i++;
    end
    chk({31'h0, tx_pin}, 32'h0);
    cyc(BITC + BITC / 2);
    for (int k = 0; k < 8; k++) begin
      tb_byte[k] = tx_pin;
      cyc(BITC);
    end
    chk({24'h0, tb_byte}, 32'ha5);
    tally_and_finish();
  end

  initial begin
    #(20000 * 8);
    errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// *** verilog/rx_deserializer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "uart_irq_params.svh"
module rx_deserializer #(
  parameter int BIT_CYCLES = `BIT_CYCLES_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rx_pin,
  output uart_irq_pkg::rx_char_s rx_char
);
  import uart_irq_pkg::*;

  localparam logic [`CNT_W-1:0] BIT_LAST = `CNT_W'(BIT_CYCLES - 1);
  localparam logic [`CNT_W-1:0] BIT_HALF = `CNT_W'(BIT_CYCLES / 2 - 1);
  localparam rx_state_s RX_RST = '{s1: 1'b1, s2: 1'b1, s3: 1'b1, level: 1'b1,
                                   st: LINE_IDLE, default: '0};

  rx_state_s q;
  rx_state_s d;

  // The line only counts as changed once the last two stages agree, so a
  // one-cycle glitch never starts a frame.
  always_comb begin
    d = q;
    d.out.valid = 1'b0;
    d.s1 = rx_pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.level = q.s3;
    end
    case (q.st)
      LINE_IDLE: begin
        if (q.level && !d.level) begin
          d.st = LINE_START;
          d.cnt = BIT_HALF;
        end
      end
      LINE_START: begin
        if (q.cnt == '0) begin
          d.st = q.level ? LINE_IDLE : LINE_DATA;
          d.cnt = BIT_LAST;
          d.bitn = 3'd0;
        end else begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      LINE_DATA: begin
        if (q.cnt == '0) begin
          d.sh = {q.level, q.sh[7:1]};
          d.cnt = BIT_LAST;
          d.bitn = q.bitn + 3'd1;
          if (q.bitn == 3'd7) begin
            d.st = LINE_STOP;
          end
        end else begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      LINE_STOP: begin
        if (q.cnt == '0) begin
          d.st = LINE_IDLE;
          d.out.valid = q.level;
          d.out.data = q.sh;
        end else begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      default: begin
        d.st = LINE_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RX_RST;
    end else begin
      q <= d;
    end
  end

  assign rx_char = q.out;
endmodule
`default_nettype wire

// *** verilog/uart_irq_enable_status.sv ***
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "uart_irq_params.svh"
module uart_irq_enable_status #(
  parameter int BIT_CYCLES = `BIT_CYCLES_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_pin,
  output logic tx_pin,
  input wire logic [1:0] dma_done_evt,
  output uart_irq_pkg::irq_req_s irq_req,
  output logic irq
);
  import uart_irq_pkg::*;

  if (BIT_CYCLES < 4 || BIT_CYCLES > 65535) begin : g_bad_bit_cycles
    $error("BIT_CYCLES must lie between 4 and 65535");
  end

  localparam logic [`CNT_W-1:0] BIT_LAST = `CNT_W'(BIT_CYCLES - 1);
  localparam top_state_s TOP_RST = '{ctrl: `CTRL_RESET,
                                     dma_mode: {`DMA_MODE_RESET, `DMA_MODE_RESET},
                                     tx_empty: 1'b1, tx_end: 1'b1, tx_line: 1'b1,
                                     tx_st: LINE_IDLE, default: '0};

  top_state_s q;
  top_state_s d;
  rx_char_s rx_char;
  logic [`IDX_W-1:0] idx;
  logic access;
  logic wr;
  logic rd;
  logic hit;
  logic wr_stat;
  logic rd_stat;
  logic clr_rx_full;
  logic clr_overrun;
  logic [31:0] rdata;
  logic [`IRQ_W-1:0] req_new;
  logic [`IRQ_W-1:0] req_old;

  rx_deserializer #(
    .BIT_CYCLES(BIT_CYCLES)
  ) u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .rx_pin(rx_pin),
    .rx_char(rx_char)
  );

  assign idx = paddr[`IDX_W+1:2];

  always_comb begin
    d = q;
    access = psel && penable && !q.pready;
    wr = psel && penable && q.pready && pwrite;
    rd = psel && penable && q.pready && !pwrite;

    hit = 1'b1;
    rdata = '0;
    if (paddr[31:`IDX_W+2] != '0 || paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end else begin
      case (idx)
        `SER_CTRL_IDX: begin
          rdata[7:0] = q.ctrl;
        end
        `SER_STAT_IDX: begin
          rdata[`STAT_TX_EMPTY] = q.tx_empty;
          rdata[`STAT_RX_FULL] = q.rx_full;
          rdata[`STAT_OVERRUN] = q.overrun;
          rdata[`STAT_TX_END] = q.tx_end;
        end
        `TX_BUF_IDX: begin
          rdata[7:0] = q.tx_buf;
        end
        `RX_BUF_IDX: begin
          rdata[7:0] = q.rx_buf;
        end
        `DMA_MODE0_IDX: begin
          rdata = q.dma_mode[0];
        end
        `DMA_MODE1_IDX: begin
          rdata = q.dma_mode[1];
        end
        `IRQ_STAT_IDX: begin
          rdata[`IRQ_W-1:0] = q.irq_stat;
        end
        `IRQ_MASK_IDX: begin
          rdata[`IRQ_W-1:0] = q.irq_mask;
        end
        default: begin
          hit = 1'b0;
        end
      endcase
    end

    // The answer is prepared one cycle into the access phase; read data are
    // taken from a register so the bus never sees a combinational path.
    d.pready = access;
    d.pslverr = access && !hit;
    if (access) begin
      d.prdata = (pwrite || !hit) ? '0 : rdata;
    end

    wr_stat = wr && hit && idx == `SER_STAT_IDX;
    rd_stat = rd && hit && idx == `SER_STAT_IDX;
    clr_rx_full = wr_stat && !pwdata[`STAT_RX_FULL] && q.rx_full_seen;
    clr_overrun = wr_stat && !pwdata[`STAT_OVERRUN] && q.overrun_seen;

    // Transmitter: a frame in progress always finishes, so dropping the
    // enable never leaves a torn character on the line.
    case (q.tx_st)
      LINE_IDLE: begin
        d.tx_line = 1'b1;
        if (q.ctrl[`CTRL_TX_ON] && !q.tx_empty) begin
          d.tx_sh = q.tx_buf;
          d.tx_empty = 1'b1;
          d.tx_st = LINE_START;
          d.tx_cnt = BIT_LAST;
          d.tx_line = 1'b0;
        end
      end
      LINE_START: begin
        if (q.tx_cnt == '0) begin
          d.tx_st = LINE_DATA;
          d.tx_cnt = BIT_LAST;
          d.tx_bit = 3'd0;
          d.tx_line = q.tx_sh[0];
        end else begin
          d.tx_cnt = q.tx_cnt - 1'b1;
        end
      end
      LINE_DATA: begin
        if (q.tx_cnt == '0) begin
          d.tx_cnt = BIT_LAST;
          d.tx_sh = {1'b1, q.tx_sh[7:1]};
          d.tx_bit = q.tx_bit + 3'd1;
          d.tx_line = q.tx_sh[1];
          if (q.tx_bit == 3'd7) begin
            d.tx_st = LINE_STOP;
            d.tx_line = 1'b1;
          end
        end else begin
          d.tx_cnt = q.tx_cnt - 1'b1;
        end
      end
      LINE_STOP: begin
        if (q.tx_cnt == '0) begin
          d.tx_st = LINE_IDLE;
          d.tx_end = q.tx_empty;
        end else begin
          d.tx_cnt = q.tx_cnt - 1'b1;
        end
      end
      default: begin
        d.tx_st = LINE_IDLE;
      end
    endcase

    if (wr && hit) begin
      case (idx)
        `SER_CTRL_IDX: begin
          d.ctrl = pwdata[7:0];
        end
        `TX_BUF_IDX: begin
          if (q.tx_empty) begin
            d.tx_buf = pwdata[7:0];
            d.tx_empty = 1'b0;
            d.tx_end = 1'b0;
          end
        end
        `DMA_MODE0_IDX: begin
          d.dma_mode[0] = pwdata;
          d.dma_mode[0][`DMA_DONE_FLAG] = q.dma_mode[0][`DMA_DONE_FLAG] &
                                          pwdata[`DMA_DONE_FLAG];
        end
        `DMA_MODE1_IDX: begin
          d.dma_mode[1] = pwdata;
          d.dma_mode[1][`DMA_DONE_FLAG] = q.dma_mode[1][`DMA_DONE_FLAG] &
                                          pwdata[`DMA_DONE_FLAG];
        end
        `IRQ_STAT_IDX: begin
          d.irq_stat = q.irq_stat & ~pwdata[`IRQ_W-1:0];
        end
        `IRQ_MASK_IDX: begin
          d.irq_mask = pwdata[`IRQ_W-1:0];
        end
        default: begin
          d.irq_mask = q.irq_mask;
        end
      endcase
    end

    // Flags only ever clear here; a 1 in the written data is simply ignored.
    if (clr_rx_full) begin
      d.rx_full = 1'b0;
      d.rx_full_seen = 1'b0;
    end
    if (clr_overrun) begin
      d.overrun = 1'b0;
      d.overrun_seen = 1'b0;
    end
    if (rd_stat && q.prdata[`STAT_RX_FULL]) begin
      d.rx_full_seen = 1'b1;
    end
    if (rd_stat && q.prdata[`STAT_OVERRUN]) begin
      d.overrun_seen = 1'b1;
    end

    // The receive enable gates only new characters; the flags and the buffer
    // are left alone when it drops.
    if (rx_char.valid && q.ctrl[`CTRL_RX_ON]) begin
      if (q.rx_full) begin
        d.overrun = 1'b1;
      end else begin
        d.rx_full = 1'b1;
        d.rx_buf = rx_char.data;
      end
    end

    for (int ch = 0; ch < 2; ch++) begin
      if (dma_done_evt[ch]) begin
        d.dma_mode[ch][`DMA_DONE_FLAG] = 1'b1;
      end
      d.req.dma_irq[ch] = d.dma_mode[ch][`DMA_DONE_FLAG] &
                          d.dma_mode[ch][`DMA_DONE_IE];
    end

    d.req.tx_empty_irq = d.tx_empty && d.ctrl[`CTRL_TXE_IE];
    d.req.tx_done_irq = d.tx_end && d.ctrl[`CTRL_TXD_IE];
    d.req.rx_full_irq = d.rx_full && d.ctrl[`CTRL_RX_IE];
    d.req.rx_err_irq = d.overrun && d.ctrl[`CTRL_RX_IE];

    // A request that rises in the cycle software clears its bit still lands.
    req_new = d.req;
    req_old = q.req;
    d.irq_stat = d.irq_stat | (req_new & ~req_old);
    d.irq = |(d.irq_stat & d.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= TOP_RST;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign tx_pin = q.tx_line;
  assign irq_req = q.req;
  assign irq = q.irq;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_char_taken;
    rx_char.valid && q.ctrl[`CTRL_RX_ON] && !q.rx_full;
  endsequence

  sequence s_char_clash;
    rx_char.valid && q.ctrl[`CTRL_RX_ON] && q.rx_full && !clr_rx_full;
  endsequence

  sequence s_access_wait;
    psel && penable && !pready;
  endsequence

  property p_tx_empty_gate;
    irq_req.tx_empty_irq |-> q.ctrl[`CTRL_TXE_IE] && q.tx_empty;
  endproperty
  a_tx_empty_gate: assert property (p_tx_empty_gate)
    else $error("transmit-empty request without its enable");

  property p_tx_done_gate;
    !q.ctrl[`CTRL_TXD_IE] |-> !irq_req.tx_done_irq;
  endproperty
  a_tx_done_gate: assert property (p_tx_done_gate)
    else $error("transmit-end request while disabled");

  property p_dma_gate;
    (irq_req.dma_irq & ~{q.dma_mode[1][`DMA_DONE_IE], q.dma_mode[0][`DMA_DONE_IE]}) == 2'b00;
  endproperty
  a_dma_gate: assert property (p_dma_gate)
    else $error("DMA transfer-end request while disabled");

  property p_rx_gate;
    irq_req.rx_full_irq == (q.rx_full && q.ctrl[`CTRL_RX_IE]) &&
    irq_req.rx_err_irq == (q.overrun && q.ctrl[`CTRL_RX_IE]);
  endproperty
  a_rx_gate: assert property (p_rx_gate)
    else $error("receive requests do not follow their joint enable");

  property p_char_store;
    s_char_taken |=> q.rx_full && q.rx_buf == $past(rx_char.data) && irq_req.rx_full_irq ==
                     q.ctrl[`CTRL_RX_IE];
  endproperty
  a_char_store: assert property (p_char_store)
    else $error("received character not stored with full flag");

  property p_full_clear;
    $fell(q.rx_full) |-> $past(wr_stat) && $past(q.rx_full_seen) &&
                         !$past(pwdata[`STAT_RX_FULL]);
  endproperty
  a_full_clear: assert property (p_full_clear)
    else $error("receive-full cleared without read then 0-write");

  property p_rx_off_hold;
    $fell(q.ctrl[`CTRL_RX_ON]) && !$past(rx_char.valid) |-> $stable(q.rx_full);
  endproperty
  a_rx_off_hold: assert property (p_rx_off_hold)
    else $error("receive-full disturbed by receive disable");

  property p_overrun;
    s_char_clash |=> q.overrun && q.rx_full && $stable(q.rx_buf);
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("character on full buffer not lost as overrun");

  property p_overrun_set;
    $rose(q.overrun) |-> $past(rx_char.valid) && $past(q.rx_full);
  endproperty
  a_overrun_set: assert property (p_overrun_set)
    else $error("overrun flag set without a clash");

  property p_overrun_clear;
    $fell(q.overrun) |-> $past(wr_stat) && $past(q.overrun_seen) &&
                         !$past(pwdata[`STAT_OVERRUN]);
  endproperty
  a_overrun_clear: assert property (p_overrun_clear)
    else $error("overrun cleared without read then 0-write");

  property p_no_write_set;
    $rose(q.rx_full) |-> $past(rx_char.valid);
  endproperty
  a_no_write_set: assert property (p_no_write_set)
    else $error("receive-full set by something other than a character");

  property p_tx_hold;
    q.tx_st == LINE_IDLE && !q.ctrl[`CTRL_TX_ON] |=> q.tx_st == LINE_IDLE && tx_pin;
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("transmitter started while disabled");

  property p_seen_latch;
    $rose(q.rx_full_seen) |-> $past(rd_stat) && $past(prdata[`STAT_RX_FULL]);
  endproperty
  a_seen_latch: assert property (p_seen_latch)
    else $error("read latch set without a read of 1");

  property p_apb_answer;
    s_access_wait |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("bus answer not one cycle into the access phase");
endmodule
`default_nettype wire

// *** verilog/uart_irq_params.svh ***
`ifndef UART_IRQ_PARAMS_SVH
`define UART_IRQ_PARAMS_SVH
`define IDX_W 24
`define DMA_MODE0_IDX 24'hfffc14
`define DMA_MODE1_IDX 24'hfffc34
`define SER_CTRL_IDX 24'hffff82
`define TX_BUF_IDX 24'hffff83
`define SER_STAT_IDX 24'hffff84
`define RX_BUF_IDX 24'hffff85
`define IRQ_STAT_IDX 24'hffff88
`define IRQ_MASK_IDX 24'hffff89
`define CTRL_TXE_IE 7
`define CTRL_RX_IE 6
`define CTRL_TX_ON 5
`define CTRL_RX_ON 4
`define CTRL_TXD_IE 2
`define CTRL_RESET 8'h00
`define STAT_TX_EMPTY 7
`define STAT_RX_FULL 6
`define STAT_OVERRUN 5
`define STAT_TX_END 2
`define DMA_DONE_IE 8
`define DMA_DONE_FLAG 16
`define DMA_MODE_RESET 32'h00000000
`define IRQ_W 6
`define CNT_W 16
`define BIT_CYCLES_DEFAULT 1085
`endif

// *** verilog/uart_irq_pkg.sv ***
`include "uart_irq_params.svh"
package uart_irq_pkg;
  typedef enum logic [1:0] {LINE_IDLE, LINE_START, LINE_DATA, LINE_STOP} line_st_e;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rx_char_s;
  typedef struct packed {
    logic [1:0] dma_irq;
    logic rx_err_irq;
    logic rx_full_irq;
    logic tx_done_irq;
    logic tx_empty_irq;
  } irq_req_s;
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    line_st_e st;
    logic [`CNT_W-1:0] cnt;
    logic [2:0] bitn;
    logic [7:0] sh;
    rx_char_s out;
  } rx_state_s;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [1:0][31:0] dma_mode;
    logic rx_full;
    logic overrun;
    logic rx_full_seen;
    logic overrun_seen;
    logic [7:0] rx_buf;
    logic [7:0] tx_buf;
    logic tx_empty;
    logic tx_end;
    line_st_e tx_st;
    logic [7:0] tx_sh;
    logic [`CNT_W-1:0] tx_cnt;
    logic [2:0] tx_bit;
    logic tx_line;
    logic [`IRQ_W-1:0] irq_stat;
    logic [`IRQ_W-1:0] irq_mask;
    irq_req_s req;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } top_state_s;
endpackage
